// ==== cwm_deadband.sv ====
// dead-band interval timer: busy for exactly the loaded number of cycles
`timescale 1ns/100ps
`default_nettype none
module cwm_deadband
  import cwm_pkg::*;
#(
  parameter int W = DB_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy
);
  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
    logic [W-1:0] lim;
  } cwm_db_state_type;

  cwm_db_state_type s;
  cwm_db_state_type n;

  // start cycle counts as the first dead cycle; zero count means none
  assign busy = start ? (load != '0) : s.run;

  // count up from one to one below the loaded value
  always_comb
  begin
    n = s;
    if (start)
    begin
      n.lim = load;
      n.cnt = {{(W-1){1'b0}}, 1'b1};
      n.run = (load > {{(W-1){1'b0}}, 1'b1});
    end
    else if (s.run)
    begin
      if (s.cnt == s.lim - {{(W-1){1'b0}}, 1'b1})
        n.run = 1'b0;
      else
        n.cnt = s.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end
endmodule
`default_nettype wire

// ==== cwm_gate_model.sv ====
// gate driver model: counts cycles in which both switches of the a/b leg conduct
`timescale 1ns/100ps
`default_nettype none
module cwm_gate_model
(
  input wire logic clk,
  input wire logic drv_a,
  input wire logic drv_b,
  output var int overlap
);
  int cnt = 0;
  // both gates of one leg on at once means shoot-through current
  always @(posedge clk)
  begin
    if (drv_a && drv_b)
      cnt <= cnt + 1;
  end
  // expose the count
  always_comb overlap = cnt;
endmodule
`default_nettype wire

// ==== cwm_pkg.sv ====
// shared constants for the complementary waveform generator
package cwm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POL = 8'h04;
  localparam logic [7:0] OFS_STEER = 8'h08;
  localparam logic [7:0] OFS_DBR = 8'h0C;
  localparam logic [7:0] OFS_DBF = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STEER_SDAT_LSB = 4;
  // values after reset
  localparam logic CTRL_EN_RST = 1'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [3:0] STR_RST = 4'h0;
  localparam logic [3:0] SDAT_RST = 4'h0;
  localparam logic [5:0] DB_RST = 6'h00;
  // mode codes
  localparam logic [2:0] M_ASYNC = 3'h0;
  localparam logic [2:0] M_SYNC = 3'h1;
  localparam logic [2:0] M_FWD = 3'h2;
  localparam logic [2:0] M_REV = 3'h3;
  localparam logic [2:0] M_HB = 3'h4;
  localparam logic [2:0] M_PP = 3'h5;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // dead-band counter width
  localparam int DB_W = 6;
endpackage

// ==== cwm_waveform_generator.sv ====
// waveform generator: six output modes behind an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module cwm_waveform_generator
  import cwm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic DATA_IN,
  input wire logic AUTO_SHDN,
  output logic OUT_A,
  output logic OUT_B,
  output logic OUT_C,
  output logic OUT_D,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    logic en;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [3:0] str;
    logic [3:0] sdat;
    logic [DB_W-1:0] dbr;
    logic [DB_W-1:0] dbf;
    logic [3:0] str_act;
    logic din_prev;
    logic seq;
    logic pp_sel;
    logic dir;
    logic [3:0] outq;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cwm_state_type;

  cwm_state_type s;
  cwm_state_type n;
  logic rise;
  logic fall;
  logic dir_chg;
  logic rstart;
  logic fstart;
  logic rbusy;
  logic fbusy;
  logic wr_go;
  logic rd_go;
  logic wr_steer;
  logic [3:0] raw;
  logic [3:0] fin;
  logic sel;

  // both full-bridge codes
  function automatic logic is_fb(input logic [2:0] m);
    return (m == M_FWD) || (m == M_REV);
  endfunction

  // address decode shared by write and read paths
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = {a[7:2], 2'b00};
    return (b == OFS_CTRL) || (b == OFS_POL) || (b == OFS_STEER) ||
           (b == OFS_DBR) || (b == OFS_DBF) || (b == OFS_STAT);
  endfunction

  // input edges and dead-band starts
  assign rise = DATA_IN & ~s.din_prev;
  assign fall = ~DATA_IN & s.din_prev;
  assign dir_chg = s.en & is_fb(s.mode) & rise & (s.mode[0] != s.dir);
  assign rstart = (s.en & (s.mode == M_HB) & rise) | (dir_chg & s.mode[0]);
  assign fstart = (s.en & (s.mode == M_HB) & fall) | (dir_chg & ~s.mode[0]);

  // rising and falling dead-band counters
  cwm_deadband #(.W(DB_W)) u_db_rise
  (
    .clk(CLK),
    .rst(SYS_RST),
    .start(rstart),
    .load(s.dbr),
    .busy(rbusy)
  );

  cwm_deadband #(.W(DB_W)) u_db_fall
  (
    .clk(CLK),
    .rst(SYS_RST),
    .start(fstart),
    .load(s.dbf),
    .busy(fbusy)
  );

  // bus handshakes: address and data taken together, one at a time
  assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~s.bvalid;
  assign rd_go = S_AXI_ARVALID & ~s.rvalid;
  assign wr_steer = wr_go & S_AXI_WSTRB[0] & ({S_AXI_AWADDR[7:2], 2'b00} == OFS_STEER);
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RRESP = s.rresp;
  assign S_AXI_RDATA = s.rdata;
  assign OUT_A = s.outq[0];
  assign OUT_B = s.outq[1];
  assign OUT_C = s.outq[2];
  assign OUT_D = s.outq[3];

  // next state: registers, sequencers, output drive
  always_comb
  begin
    n = s;
    raw = 4'h0;
    fin = 4'h0;
    sel = 1'b0;
    n.din_prev = DATA_IN;
    // register writes, only the low byte lane holds bits
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp = mapped(S_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR;
      if (S_AXI_WSTRB[0])
      begin
        case ({S_AXI_AWADDR[7:2], 2'b00})
          OFS_CTRL:
          begin
            n.en = S_AXI_WDATA[CTRL_EN_BIT];
            n.mode = S_AXI_WDATA[CTRL_MODE_LSB +: 3];
          end
          OFS_POL: n.pol = S_AXI_WDATA[3:0];
          OFS_STEER:
          begin
            n.str = S_AXI_WDATA[3:0];
            n.sdat = S_AXI_WDATA[STEER_SDAT_LSB +: 4];
          end
          OFS_DBR: n.dbr = S_AXI_WDATA[DB_W-1:0];
          OFS_DBF: n.dbf = S_AXI_WDATA[DB_W-1:0];
          default: n.dbf = s.dbf;
        endcase
      end
    end
    else if (s.bvalid && S_AXI_BREADY)
      n.bvalid = 1'b0;
    // register reads
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case ({S_AXI_ARADDR[7:2], 2'b00})
        OFS_CTRL: n.rdata = {28'h000_0000, s.mode, s.en};
        OFS_POL: n.rdata = {28'h000_0000, s.pol};
        OFS_STEER: n.rdata = {24'h00_0000, s.sdat, s.str};
        OFS_DBR: n.rdata = {26'h000_0000, s.dbr};
        OFS_DBF: n.rdata = {26'h000_0000, s.dbf};
        OFS_STAT: n.rdata = {24'h00_0000, s.seq, s.dir, rbusy, fbusy, s.outq};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    else if (s.rvalid && S_AXI_RREADY)
      n.rvalid = 1'b0;
    // steer selects: immediate in async, at input rise in sync
    if (!s.en || s.mode == M_ASYNC)
      n.str_act = n.str;
    else if (s.mode == M_SYNC && rise)
      n.str_act = n.str;
    // push-pull sequencer, back to output A on disable or shutdown
    if (!s.en || AUTO_SHDN)
    begin
      n.seq = 1'b0;
      n.pp_sel = 1'b0;
    end
    else if (s.mode == M_PP && rise)
    begin
      n.pp_sel = s.seq;
      n.seq = ~s.seq;
    end
    // applied direction follows the mode every cycle while disabled, at the next input rise when enabled in full bridge
    if (!s.en)
      n.dir = s.mode[0];
    else if (dir_chg)
      n.dir = s.mode[0];
    // raw active levels, then per-output polarity
    case (s.mode)
      M_ASYNC, M_SYNC:
      begin
        for (int i = 0; i < 4; i++)
          fin[i] = n.str_act[i] ? (DATA_IN ^ s.pol[i]) : n.sdat[i];
      end
      M_FWD, M_REV:
      begin
        if (!n.dir)
          raw = {DATA_IN & ~fbusy, 1'b0, 1'b0, 1'b1};
        else
          raw = {1'b0, 1'b1, DATA_IN & ~rbusy, 1'b0};
        fin = raw ^ s.pol;
      end
      M_HB:
      begin
        raw[0] = DATA_IN & ~rbusy;
        raw[1] = ~DATA_IN & ~fbusy;
        raw[3:2] = raw[1:0];
        fin = raw ^ s.pol;
      end
      M_PP:
      begin
        sel = rise ? s.seq : s.pp_sel;
        raw[0] = DATA_IN & ~sel;
        raw[1] = DATA_IN & sel;
        raw[3:2] = raw[1:0];
        fin = raw ^ s.pol;
      end
      default: fin = s.pol;
    endcase
    n.outq = s.en ? fin : 4'h0;
  end

  // single state register
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      s <= '0;
      s.en <= CTRL_EN_RST;
      s.mode <= MODE_RST;
      s.pol <= POL_RST;
      s.str <= STR_RST;
      s.str_act <= STR_RST;
      s.sdat <= SDAT_RST;
      s.dbr <= DB_RST;
      s.dbf <= DB_RST;
    end
    else
      s <= n;
  end

  // checks on the outputs, the push-pull sequencer, the applied direction and the steering selects
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_disabled_outs_clear: assert property (!s.en |=> s.outq == 4'h0)
    else $error("outputs not cleared while disabled");

  a_pp_seq_reset: assert property ((!s.en || AUTO_SHDN) |=> !s.seq)
    else $error("push-pull sequencer not reset");

  a_pp_first_a: assert property ((s.en && s.mode == M_PP && rise && !s.seq)
    |=> (OUT_A == ~$past(s.pol[0])) && (OUT_B == $past(s.pol[1])) && (OUT_C == ~$past(s.pol[2])))
    else $error("push-pull pulse not on output A");

  a_pp_no_overlap: assert property ((s.en && s.mode == M_PP)
    |=> !((OUT_A ^ $past(s.pol[0])) && (OUT_B ^ $past(s.pol[1]))))
    else $error("push-pull outputs active together");

  a_fb_fwd_levels: assert property ((s.en && s.mode == M_FWD && !s.dir)
    |=> OUT_A == ~$past(s.pol[0]) && OUT_B == $past(s.pol[1]) && OUT_C == $past(s.pol[2]))
    else $error("forward full-bridge levels wrong");

  a_fb_rev_levels: assert property ((s.en && s.mode == M_REV && s.dir)
    |=> OUT_C == ~$past(s.pol[2]) && OUT_A == $past(s.pol[0]) && OUT_D == $past(s.pol[3]))
    else $error("reverse full-bridge levels wrong");

  a_dir_wait_rise: assert property ((s.en && is_fb(s.mode) && s.mode[0] != s.dir && !rise)
    |=> s.dir == $past(s.dir))
    else $error("direction changed without input rise");

  a_dir_deadband: assert property ((dir_chg && s.mode[0] && s.dbr > 6'h01)
    |=> OUT_B == $past(s.pol[1]) ##1 OUT_B == $past(s.pol[1]))
    else $error("modulated output started inside dead band");

  a_fwd_deadband: assert property ((dir_chg && !s.mode[0] && s.dbf > 6'h01)
    |=> OUT_D == $past(s.pol[3]) ##1 OUT_D == $past(s.pol[3]))
    else $error("forward modulated output started inside dead band");

  a_steer_static: assert property ((s.en && s.mode == M_ASYNC && !n.str_act[0])
    |=> OUT_A == $past(n.sdat[0]))
    else $error("static steering level wrong");

  a_sync_steer_hold: assert property ((s.en && s.mode == M_SYNC && !rise)
    |=> s.str_act == $past(s.str_act))
    else $error("sync steering changed off input rise");

  a_async_steer_now: assert property ((s.en && s.mode == M_ASYNC && wr_steer)
    |=> s.str_act == $past(S_AXI_WDATA[3:0]))
    else $error("async steering not applied after write");

  a_hb_rise_delay: assert property ((s.en && s.mode == M_HB && rise && s.dbr != 6'h00)
    |=> OUT_A == $past(s.pol[0]))
    else $error("half-bridge output A on without dead band");

  a_hb_fall_delay: assert property ((s.en && s.mode == M_HB && fall && s.dbf != 6'h00)
    |=> OUT_B == $past(s.pol[1]))
    else $error("half-bridge output B on without dead band");

  a_hb_copy_pair: assert property ((s.en && s.mode == M_HB)
    |=> ((OUT_C ^ $past(s.pol[2])) == (OUT_A ^ $past(s.pol[0])))
    && ((OUT_D ^ $past(s.pol[3])) == (OUT_B ^ $past(s.pol[1]))))
    else $error("half-bridge third or fourth output not a copy");

  a_reserved_idle: assert property ((s.en && s.mode[2:1] == 2'b11)
    |=> {OUT_D, OUT_C, OUT_B, OUT_A} == $past(s.pol))
    else $error("reserved mode outputs not inactive");
endmodule
`default_nettype wire

// ==== tb_cwm_waveform_generator.sv ====
// testbench for the waveform generator: register access and every output mode
`timescale 1ns/100ps
`default_nettype none
module tb_cwm_waveform_generator import cwm_pkg::*;;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic din = 1'h0;
  logic shdn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, oa, ob, oc, od;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] outs;
  logic [2:0] cur = M_ASYNC;
  logic [7:0] ofs [6] = '{OFS_CTRL, OFS_POL, OFS_STEER, OFS_DBR, OFS_DBF, OFS_STAT};
  int checks = 0;
  int mismatches = 0;
  int overlap;
  assign outs = {od, oc, ob, oa};
  // design under test and the gate driver on its outputs A and B
  cwm_waveform_generator u_cwm_waveform_generator (.CLK(clk), .SYS_RST(rst), .DATA_IN(din), .AUTO_SHDN(shdn),
    .OUT_A(oa), .OUT_B(ob), .OUT_C(oc), .OUT_D(od), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  cwm_gate_model u_cwm_gate_model (.clk(clk), .drv_a(oa), .drv_b(ob), .overlap(overlap));
  // clock source
  always #25 clk = ~clk;
  // compare one value and count it
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus write: each channel released at the rising edge that takes it, response taken at its edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'h1;
    w_pend = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (aw_pend || w_pend)
    begin
      @(posedge clk);
      if (aw_pend && awready === 1'h1)
      begin
        awvalid <= 1'h0;
        aw_pend = 1'h0;
      end
      if (w_pend && wready === 1'h1)
      begin
        wvalid <= 1'h0;
        w_pend = 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge clk); while (bvalid !== 1'h1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'h0;
  endtask
  // bus read: address released when taken, data compared at the edge where rvalid is high
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk); while (rvalid !== 1'h1);
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'h0;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
  endtask
  // check outputs between edges, return on the next rising edge
  task automatic ckout(input logic [3:0] e);
    @(negedge clk);
    chk("outs", {28'h0, outs}, {28'h0, e});
    @(posedge clk);
  endtask
  task automatic ctl(input logic [2:0] m, input logic e);
    wr(OFS_CTRL, {28'h0, m, e}, RESP_OKAY);
  endtask
  // mode is only changed while disabled
  task automatic swm(input logic [2:0] m);
    ctl(cur, 1'h0);
    ctl(m, 1'h0);
    ctl(m, 1'h1);
    cur = m;
  endtask
  // one input pulse, outputs checked while it is high
  task automatic pulse(input logic [3:0] e);
    din <= 1'h1;
    edges(2);
    ckout(e);
    din <= 1'h0;
    edges(3);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
  // main sequence
  initial
  begin
    edges(10);
    rst <= 1'h0;
    ckout(4'h0);
    foreach (ofs[i])
      rd(ofs[i], 32'h0000_0000, RESP_OKAY);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_POL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_POL, 32'h0000_000F, RESP_OKAY);
    // low byte lane not strobed: register keeps its value
    wstrb <= 4'hE;
    wr(OFS_POL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_POL, 32'h0000_000F, RESP_OKAY);
    // half-bridge with rising 2, falling 3 and the fourth output inverted
    wr(OFS_DBR, 32'h0000_0002, RESP_OKAY);
    wr(OFS_DBF, 32'h0000_0003, RESP_OKAY);
    wr(OFS_POL, 32'h0000_0008, RESP_OKAY);
    swm(M_HB);
    edges(3);
    din <= 1'h1;
    edges(2);
    ckout(4'h8);
    ckout(4'hD);
    din <= 1'h0;
    edges(3);
    ckout(4'h8);
    ckout(4'h2);
    chk("overlap", overlap, 0);
    // push-pull alternation and sequencer restart
    wr(OFS_POL, 32'h0000_0000, RESP_OKAY);
    swm(M_PP);
    pulse(4'h5);
    pulse(4'hA);
    shdn <= 1'h1;
    edges(1);
    shdn <= 1'h0;
    edges(1);
    pulse(4'h5);
    swm(M_PP);
    pulse(4'h5);
    // asynchronous steering with all outputs inverted
    wr(OFS_POL, 32'h0000_000F, RESP_OKAY);
    wr(OFS_STEER, 32'h0000_00A5, RESP_OKAY);
    swm(M_ASYNC);
    din <= 1'h1;
    edges(2);
    ckout(4'hA);
    wr(OFS_STEER, 32'h0000_0010, RESP_OKAY);
    ckout(4'h1);
    din <= 1'h0;
    // synchronous steering
    wr(OFS_POL, 32'h0000_0000, RESP_OKAY);
    wr(OFS_STEER, 32'h0000_0001, RESP_OKAY);
    swm(M_SYNC);
    din <= 1'h1;
    edges(2);
    ckout(4'h1);
    wr(OFS_STEER, 32'h0000_0020, RESP_OKAY);
    ckout(4'h3);
    din <= 1'h0;
    edges(2);
    ckout(4'h2);
    din <= 1'h1;
    edges(2);
    ckout(4'h2);
    din <= 1'h0;
    // full bridge forward, then reverse while enabled
    swm(M_FWD);
    din <= 1'h1;
    edges(2);
    ckout(4'h9);
    ctl(M_REV, 1'h1);
    cur = M_REV;
    ckout(4'h9);
    din <= 1'h0;
    edges(2);
    ckout(4'h1);
    din <= 1'h1;
    edges(1);
    ckout(4'h4);
    ckout(4'h4);
    ckout(4'h6);
    din <= 1'h0;
    edges(2);
    ckout(4'h4);
    din <= 1'h1;
    edges(1);
    ckout(4'h6);
    din <= 1'h0;
    // back to forward while enabled: D waits out the falling dead band of 3
    ctl(M_FWD, 1'h1);
    cur = M_FWD;
    edges(2);
    din <= 1'h1;
    edges(1);
    ckout(4'h1);
    ckout(4'h1);
    ckout(4'h1);
    ckout(4'h9);
    din <= 1'h0;
    // disabled outputs ignore polarity, reserved codes sit inactive
    wr(OFS_POL, 32'h0000_0005, RESP_OKAY);
    ctl(M_FWD, 1'h0);
    ckout(4'h0);
    for (int i = 6; i < 8; i++)
    begin
      swm(3'(i));
      edges(1);
      ckout(4'h5);
    end
    results;
  end
endmodule
`default_nettype wire
